// >>> verilog/crafe_pkg.sv
// constants and types of the fieldbus register access front end
// Overview of operation
// - user index minus 0x2001 gives the internal register number
// - float registers travel as 32-bit single precision words
// - 0xFF00 to remote register requests remote, 0x0000 returns local
// - set-value writes refused unless remote control was granted
// - set values are percent codes, 0x0000 is 0 and 0xCCCC is 100
// - accepted set values are quantised to 26214 effective steps
// - at most four data bytes per message, one point value each
// - each point value is checked against full scale 0xCCCC when written
// - writing 0xFF00 to submit copies loaded points, arms generator if a mode is selected
// - generator uses zero or submitted data, never unsubmitted points
// - point data refused until voltage or current mode selected
// - 99 points at indexes 0x2385 onward, eight values by sub-index
// - writing 0x0000 to the chosen select register leaves the generator
// - distinct aborts for missing object, bad command, missing sub-index, access
// - distinct aborts for too much data, too little, out of range
// - aborts for state conflict; out of memory and general error codes defined, never raised
// - raw link: first two bytes pick register, identifier picks write or read
// - base id writes, base plus one queries, base plus two responses
// - errors on base or query id frames send an unsolicited response on the response id
// - query and response ids follow the base id
// - broadcast id accepts writes only, never queries or answers
// - error response carries register 65535 and a one-byte code
package crafe_pkg;
	localparam logic [15:0] CRAFE_INDEX_OFFSET = 16'h2001;
	localparam logic [15:0] CRAFE_IDX_NOMINAL_V = 16'h207A;
	localparam logic [15:0] CRAFE_IDX_REMOTE = 16'h2193;
	localparam logic [15:0] CRAFE_IDX_SETV = 16'h21F5;
	localparam logic [15:0] CRAFE_IDX_SETI = 16'h21F6;
	localparam logic [15:0] CRAFE_IDX_GLIM_V = 16'h21F5;
	localparam logic [15:0] CRAFE_IDX_GLIM_I = 16'h21F6;
	localparam logic [15:0] CRAFE_IDX_GLIM_P = 16'h21F7;
	localparam logic [15:0] CRAFE_IDX_GEN_RUN = 16'h2353;
	localparam logic [15:0] CRAFE_IDX_GEN_VSEL = 16'h2354;
	localparam logic [15:0] CRAFE_IDX_GEN_ISEL = 16'h2355;
	localparam logic [15:0] CRAFE_IDX_SEQ_START = 16'h235C;
	localparam logic [15:0] CRAFE_IDX_SEQ_END = 16'h235D;
	localparam logic [15:0] CRAFE_IDX_SUBMIT = 16'h235F;
	localparam logic [15:0] CRAFE_IDX_REPEAT = 16'h0861;
	localparam logic [15:0] CRAFE_IDX_PT_FIRST = 16'h2385;
	localparam logic [15:0] CRAFE_IDX_PT_LAST = 16'h29A5;
	localparam int CRAFE_POINTS = 99;
	localparam int CRAFE_PT_VALUES = 8;
	localparam logic [7:0] CRAFE_PT_STRIDE = 8'h10;
	localparam logic [15:0] CRAFE_CODE_ON = 16'hFF00;
	localparam logic [15:0] CRAFE_CODE_OFF = 16'h0000;
	localparam logic [15:0] CRAFE_FULL_SCALE = 16'hCCCC;
	localparam logic [15:0] CRAFE_REG_ERROR = 16'hFFFF;
	localparam logic [31:0] CRAFE_AB_NO_OBJ = 32'h06020000;
	localparam logic [31:0] CRAFE_AB_NO_CMD = 32'h06040043;
	localparam logic [31:0] CRAFE_AB_NO_SUB = 32'h06099911;
	localparam logic [31:0] CRAFE_AB_ACCESS = 32'h06010002;
	localparam logic [31:0] CRAFE_AB_TOO_MUCH = 32'h06070012;
	localparam logic [31:0] CRAFE_AB_TOO_LITTLE = 32'h06070013;
	localparam logic [31:0] CRAFE_AB_RANGE = 32'h06090030;
	localparam logic [31:0] CRAFE_AB_STATE = 32'h08000022;
	localparam logic [31:0] CRAFE_AB_MEMORY = 32'h05040005;
	localparam logic [31:0] CRAFE_AB_GENERAL = 32'h0800000;
	localparam logic [7:0] CRAFE_EC_NONE = 8'h00;
	localparam logic [7:0] CRAFE_EC_FUNC = 8'h01;
	localparam logic [7:0] CRAFE_EC_ADDR = 8'h02;
	localparam logic [7:0] CRAFE_EC_VALUE = 8'h03;
	localparam logic [7:0] CRAFE_EC_STATE = 8'h04;
	localparam logic [10:0] CRAFE_BASE_ID_RST = 11'h000;
	localparam logic [10:0] CRAFE_BCAST_ID_RST = 11'h7FF;
	typedef enum logic [1:0] {
		CRAFE_OP_WRITE = 2'b00,
		CRAFE_OP_READ = 2'b01,
		CRAFE_OP_BAD = 2'b10
	} crafe_op_t;
endpackage

// >>> verilog/crafe_top.sv
// register access front end: object dictionary and raw identifier paths
`timescale 1ns/1ps
module crafe_top (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// object dictionary request
	input wire logic od_req,
	input wire crafe_pkg::crafe_op_t od_op,
	input wire logic [15:0] od_index,
	input wire logic [7:0] od_sub,
	input wire logic [2:0] od_len,
	input wire logic [31:0] od_wdata,
	// object dictionary answer
	output logic od_done,
	output logic od_abort,
	output logic [31:0] od_abort_code,
	output logic [31:0] od_rdata,
	// raw frame receive
	input wire logic rx_valid,
	input wire logic [10:0] rx_id,
	input wire logic [3:0] rx_dlc,
	input wire logic [63:0] rx_data,
	// raw frame transmit
	output logic tx_valid,
	output logic [10:0] tx_id,
	output logic [3:0] tx_dlc,
	output logic [63:0] tx_data,
	// identifier configuration
	input wire logic cfg_we,
	input wire logic [10:0] cfg_base_id,
	input wire logic [10:0] cfg_bcast_id,
	// device side
	input wire logic [31:0] nominal_v_float,
	input wire logic remote_allowed,
	output logic remote_active,
	output logic [15:0] set_voltage,
	output logic [15:0] set_current,
	output logic gen_armed,
	output logic gen_run,
	output logic gen_on_current,
	output logic [15:0] gen_start_point,
	output logic [15:0] gen_end_point,
	output logic [15:0] gen_repeat,
	output logic [15:0] gen_vlimit,
	output logic [15:0] gen_ilimit,
	output logic [15:0] gen_plimit
);
	import crafe_pkg::*;

	typedef struct packed {
		logic od_done;
		logic od_abort;
		logic [31:0] od_abort_code;
		logic [31:0] od_rdata;
		logic tx_valid;
		logic [10:0] tx_id;
		logic [3:0] tx_dlc;
		logic [63:0] tx_data;
		logic [10:0] base_id;
		logic [10:0] bcast_id;
		logic remote;
		logic vsel;
		logic isel;
		logic armed;
		logic run;
		logic [15:0] start_pt;
		logic [15:0] end_pt;
		logic [15:0] repeat_cnt;
		logic [15:0] vlim;
		logic [15:0] ilim;
		logic [15:0] plim;
	} crafe_state_t;

	crafe_state_t state_reg;
	crafe_state_t state_next;

	// sequence point storage: loaded and submitted copies
	logic [15:0] load_mem [0:CRAFE_POINTS*CRAFE_PT_VALUES-1];
	logic [15:0] live_mem [0:CRAFE_POINTS*CRAFE_PT_VALUES-1];

	// shared access decode, one request per cycle, object path first
	logic acc_valid;
	logic acc_write;
	logic acc_raw;
	logic acc_bcast;
	logic [15:0] acc_reg;
	logic [7:0] acc_sub;
	logic [15:0] acc_val;
	logic [2:0] acc_len;
	logic [15:0] acc_index;
	logic pt_hit;
	logic [15:0] pt_off;
	logic [9:0] pt_addr;
	logic [15:0] quant;
	logic [15:0] rd_val;
	logic [31:0] ab_code;
	logic [7:0] ec_code;
	logic pt_write;
	logic submit;

	always_comb begin
		acc_raw = 1'b0;
		acc_bcast = 1'b0;
		acc_valid = od_req;
		acc_write = (od_op == CRAFE_OP_WRITE);
		acc_index = od_index;
		acc_sub = od_sub;
		acc_val = od_wdata[15:0];
		acc_len = od_len;
		if (!od_req && rx_valid) begin
			// identifier picks direction, first two bytes pick register
			acc_raw = 1'b1;
			acc_sub = rx_data[23:16];
			acc_val = rx_data[39:24];
			acc_len = 3'd2;
			acc_index = 16'(rx_data[15:0] + CRAFE_INDEX_OFFSET);
			acc_bcast = (rx_id == state_reg.bcast_id);
			acc_valid = (rx_id == state_reg.base_id) || (rx_id == state_reg.base_id + 11'h001) || acc_bcast;
			acc_write = (rx_id == state_reg.base_id) || acc_bcast;
		end
		acc_reg = acc_index - CRAFE_INDEX_OFFSET;
	end

	// point index decode, sub-index 1..8 selects the value
	always_comb begin
		pt_off = acc_index - CRAFE_IDX_PT_FIRST;
		pt_hit = (acc_index >= CRAFE_IDX_PT_FIRST) && (acc_index <= CRAFE_IDX_PT_LAST)
			&& (pt_off[3:0] == 4'h0) && (pt_off[15:4] < 12'(CRAFE_POINTS));
		pt_addr = 10'({pt_off[10:4], 3'b000} + {7'h00, 3'(acc_sub - 8'h01)});
		quant = {acc_val[15:1], 1'b0};
	end

	// register read mux
	always_comb begin
		rd_val = 16'h0000;
		unique case (acc_index)
			CRAFE_IDX_REMOTE: rd_val = state_reg.remote ? CRAFE_CODE_ON : CRAFE_CODE_OFF;
			CRAFE_IDX_GLIM_V: rd_val = state_reg.vlim;
			CRAFE_IDX_GLIM_I: rd_val = state_reg.ilim;
			CRAFE_IDX_GLIM_P: rd_val = state_reg.plim;
			CRAFE_IDX_GEN_RUN: rd_val = state_reg.run ? CRAFE_CODE_ON : CRAFE_CODE_OFF;
			CRAFE_IDX_GEN_VSEL: rd_val = state_reg.vsel ? CRAFE_CODE_ON : CRAFE_CODE_OFF;
			CRAFE_IDX_GEN_ISEL: rd_val = state_reg.isel ? CRAFE_CODE_ON : CRAFE_CODE_OFF;
			CRAFE_IDX_SEQ_START: rd_val = state_reg.start_pt;
			CRAFE_IDX_SEQ_END: rd_val = state_reg.end_pt;
			CRAFE_IDX_REPEAT: rd_val = state_reg.repeat_cnt;
			default: rd_val = 16'h0000;
		endcase
	end

	// access check, abort code selection
	always_comb begin
		ab_code = 32'h0000_0000;
		ec_code = CRAFE_EC_NONE;
		pt_write = 1'b0;
		submit = 1'b0;
		if (acc_valid) begin
			if (!acc_raw && od_op == CRAFE_OP_BAD) begin
				ab_code = CRAFE_AB_NO_CMD;
				ec_code = CRAFE_EC_FUNC;
			end else if (pt_hit) begin
				if (!acc_write) begin
					ab_code = CRAFE_AB_ACCESS;
					ec_code = CRAFE_EC_FUNC;
				end else if (acc_sub == 8'h00 || acc_sub > 8'(CRAFE_PT_VALUES)) begin
					ab_code = CRAFE_AB_NO_SUB;
					ec_code = CRAFE_EC_ADDR;
				end else if (acc_len > 3'd4) begin
					ab_code = CRAFE_AB_TOO_MUCH;
					ec_code = CRAFE_EC_VALUE;
				end else if (acc_len < 3'd2) begin
					ab_code = CRAFE_AB_TOO_LITTLE;
					ec_code = CRAFE_EC_VALUE;
				end else if (!state_reg.vsel && !state_reg.isel) begin
					ab_code = CRAFE_AB_STATE;
					ec_code = CRAFE_EC_STATE;
				end else if (acc_val > CRAFE_FULL_SCALE) begin
					ab_code = CRAFE_AB_RANGE;
					ec_code = CRAFE_EC_VALUE;
				end else begin
					pt_write = 1'b1;
				end
			end else if (acc_write) begin
				if (acc_len > 3'd4) begin
					ab_code = CRAFE_AB_TOO_MUCH;
					ec_code = CRAFE_EC_VALUE;
				end else if (acc_len < 3'd2) begin
					ab_code = CRAFE_AB_TOO_LITTLE;
					ec_code = CRAFE_EC_VALUE;
				end else begin
					unique case (acc_index)
						CRAFE_IDX_NOMINAL_V: begin
							ab_code = CRAFE_AB_ACCESS;
							ec_code = CRAFE_EC_FUNC;
						end
						CRAFE_IDX_REMOTE: begin
							if (acc_val != CRAFE_CODE_ON && acc_val != CRAFE_CODE_OFF) begin
								ab_code = CRAFE_AB_RANGE;
								ec_code = CRAFE_EC_VALUE;
							end else if (acc_val == CRAFE_CODE_ON && !remote_allowed) begin
								ab_code = CRAFE_AB_STATE;
								ec_code = CRAFE_EC_STATE;
							end
						end
						CRAFE_IDX_SUBMIT: begin
							if (!state_reg.remote) begin
								ab_code = CRAFE_AB_STATE;
								ec_code = CRAFE_EC_STATE;
							end else if (acc_val == CRAFE_CODE_ON) begin
								submit = 1'b1;
							end
						end
						CRAFE_IDX_GLIM_V, CRAFE_IDX_GLIM_I, CRAFE_IDX_GLIM_P, CRAFE_IDX_GEN_RUN,
						CRAFE_IDX_GEN_VSEL, CRAFE_IDX_GEN_ISEL, CRAFE_IDX_SEQ_START, CRAFE_IDX_SEQ_END,
						CRAFE_IDX_REPEAT: begin
							if (!state_reg.remote) begin
								ab_code = CRAFE_AB_STATE;
								ec_code = CRAFE_EC_STATE;
							end else if (acc_val > CRAFE_FULL_SCALE && acc_index != CRAFE_IDX_GEN_RUN
								&& acc_index != CRAFE_IDX_GEN_VSEL && acc_index != CRAFE_IDX_GEN_ISEL
								&& acc_index != CRAFE_IDX_REPEAT && acc_index != CRAFE_IDX_SEQ_START
								&& acc_index != CRAFE_IDX_SEQ_END) begin
								ab_code = CRAFE_AB_RANGE;
								ec_code = CRAFE_EC_VALUE;
							end
						end
						default: begin
							ab_code = CRAFE_AB_NO_OBJ;
							ec_code = CRAFE_EC_ADDR;
						end
					endcase
				end
			end else if (acc_index == CRAFE_IDX_SUBMIT) begin
				ab_code = CRAFE_AB_ACCESS;
				ec_code = CRAFE_EC_FUNC;
			end else if (acc_index != CRAFE_IDX_NOMINAL_V && acc_index != CRAFE_IDX_REMOTE
				&& acc_index != CRAFE_IDX_SETV && acc_index != CRAFE_IDX_GLIM_I
				&& acc_index != CRAFE_IDX_GLIM_P && acc_index != CRAFE_IDX_GEN_RUN
				&& acc_index != CRAFE_IDX_GEN_VSEL && acc_index != CRAFE_IDX_GEN_ISEL
				&& acc_index != CRAFE_IDX_SEQ_START && acc_index != CRAFE_IDX_SEQ_END
				&& acc_index != CRAFE_IDX_REPEAT) begin
				ab_code = CRAFE_AB_NO_OBJ;
				ec_code = CRAFE_EC_ADDR;
			end
		end
	end

	// next state
	always_comb begin
		state_next = state_reg;
		state_next.od_done = 1'b0;
		state_next.tx_valid = 1'b0;
		if (cfg_we) begin
			state_next.base_id = cfg_base_id;
			state_next.bcast_id = cfg_bcast_id;
		end
		if (acc_valid) begin
			if (!acc_raw) begin
				state_next.od_done = 1'b1;
				state_next.od_abort = (ab_code != 32'h0000_0000);
				state_next.od_abort_code = ab_code;
				state_next.od_rdata = (acc_index == CRAFE_IDX_NOMINAL_V) ? nominal_v_float : {16'h0000, rd_val};
			end else if (ec_code != CRAFE_EC_NONE && !acc_bcast) begin
				state_next.tx_valid = 1'b1;
				state_next.tx_id = state_reg.base_id + 11'h002;
				state_next.tx_dlc = 4'h3;
				state_next.tx_data = {40'h00_0000_0000, ec_code, CRAFE_REG_ERROR};
			end else if (!acc_write && !acc_bcast) begin
				state_next.tx_valid = 1'b1;
				state_next.tx_id = state_reg.base_id + 11'h002;
				state_next.tx_dlc = 4'h6;
				state_next.tx_data = {16'h0000, (acc_index == CRAFE_IDX_NOMINAL_V) ? nominal_v_float
					: {16'h0000, rd_val}, acc_reg};
			end
			if (acc_write && ab_code == 32'h0000_0000) begin
				unique case (acc_index)
					CRAFE_IDX_REMOTE: state_next.remote = (acc_val == CRAFE_CODE_ON);
					CRAFE_IDX_GLIM_V: state_next.vlim = quant;
					CRAFE_IDX_GLIM_I: state_next.ilim = quant;
					CRAFE_IDX_GLIM_P: state_next.plim = quant;
					CRAFE_IDX_GEN_RUN: state_next.run = state_reg.armed && (acc_val == CRAFE_CODE_ON);
					CRAFE_IDX_GEN_VSEL: state_next.vsel = (acc_val != CRAFE_CODE_OFF);
					CRAFE_IDX_GEN_ISEL: state_next.isel = (acc_val != CRAFE_CODE_OFF);
					CRAFE_IDX_SEQ_START: state_next.start_pt = acc_val;
					CRAFE_IDX_SEQ_END: state_next.end_pt = acc_val;
					CRAFE_IDX_REPEAT: state_next.repeat_cnt = acc_val;
					default: ;
				endcase
				if (submit) begin
					state_next.armed = 1'b1;
				end
			end
		end
		if (!state_next.vsel && !state_next.isel) begin
			state_next.armed = 1'b0;
			state_next.run = 1'b0;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg <= '0;
			state_reg.base_id <= CRAFE_BASE_ID_RST;
			state_reg.bcast_id <= CRAFE_BCAST_ID_RST;
		end else begin
			state_reg <= state_next;
		end
	end

	// point storage, submitted copy feeds the generator only
	genvar gi;
	generate
		for (gi = 0; gi < CRAFE_POINTS * CRAFE_PT_VALUES; gi++) begin : g_pt
			always_ff @(posedge clk or posedge sys_rst) begin
				if (sys_rst) begin
					load_mem[gi] <= 16'h0000;
					live_mem[gi] <= 16'h0000;
				end else begin
					if (pt_write && pt_addr == 10'(gi)) begin
						load_mem[gi] <= acc_val;
					end
					if (submit) begin
						live_mem[gi] <= load_mem[gi];
					end
				end
			end
		end
	endgenerate

	assign od_done = state_reg.od_done;
	assign od_abort = state_reg.od_abort;
	assign od_abort_code = state_reg.od_abort_code;
	assign od_rdata = state_reg.od_rdata;
	assign tx_valid = state_reg.tx_valid;
	assign tx_id = state_reg.tx_id;
	assign tx_dlc = state_reg.tx_dlc;
	assign tx_data = state_reg.tx_data;
	assign remote_active = state_reg.remote;
	assign set_voltage = state_reg.vlim;
	assign set_current = state_reg.ilim;
	assign gen_armed = state_reg.armed;
	assign gen_run = state_reg.run;
	assign gen_on_current = state_reg.isel;
	assign gen_start_point = state_reg.start_pt;
	assign gen_end_point = state_reg.end_pt;
	assign gen_repeat = state_reg.repeat_cnt;
	assign gen_vlimit = state_reg.vlim;
	assign gen_ilimit = state_reg.ilim;
	assign gen_plimit = state_reg.plim;
endmodule

// >>> sim/crafe_checker_sva.sv
// concurrent checks on the front end ports
`timescale 1ns/1ps
module crafe_checker
	import crafe_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// object request and answer
	input wire logic od_req,
	input wire crafe_pkg::crafe_op_t od_op,
	input wire logic [15:0] od_index,
	input wire logic [2:0] od_len,
	input wire logic [31:0] od_wdata,
	input wire logic od_done,
	input wire logic od_abort,
	input wire logic [31:0] od_abort_code,
	// raw frames and identifiers
	input wire logic rx_valid,
	input wire logic [10:0] rx_id,
	input wire logic tx_valid,
	input wire logic [10:0] tx_id,
	input wire logic [3:0] tx_dlc,
	input wire logic [63:0] tx_data,
	input wire logic cfg_we,
	input wire logic [10:0] cfg_base_id,
	input wire logic [10:0] cfg_bcast_id,
	// device side
	input wire logic remote_allowed,
	input wire logic remote_active,
	input wire logic [15:0] set_voltage,
	input wire logic gen_armed,
	input wire logic gen_run
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	logic [10:0] base_reg;
	logic [10:0] bcast_reg;
	logic submit_reg;
	// identifier and submit tracking
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			base_reg <= CRAFE_BASE_ID_RST;
			bcast_reg <= CRAFE_BCAST_ID_RST;
			submit_reg <= 1'b0;
		end else begin
			if (cfg_we) begin
				base_reg <= cfg_base_id;
				bcast_reg <= cfg_bcast_id;
			end
			submit_reg <= od_req && od_op == CRAFE_OP_WRITE && od_index == CRAFE_IDX_SUBMIT;
		end
	end
	property p_answer; od_req |=> od_done; endproperty
	a_answer: assert property (p_answer) else $error("no answer after object request");
	property p_bad_cmd; od_req && od_op == CRAFE_OP_BAD |=> od_abort && od_abort_code == CRAFE_AB_NO_CMD; endproperty
	a_bad_cmd: assert property (p_bad_cmd) else $error("bad command not aborted");
	property p_len_long;
		od_req && od_op == CRAFE_OP_WRITE && od_index == CRAFE_IDX_SETV && remote_active && od_len > 3'h4
		|=> od_abort && od_abort_code == CRAFE_AB_TOO_MUCH;
	endproperty
	a_len_long: assert property (p_len_long) else $error("long write not aborted");
	property p_local_refuse;
		od_req && od_op == CRAFE_OP_WRITE && od_index == CRAFE_IDX_SETV && !remote_active
		|=> od_abort && od_abort_code == CRAFE_AB_STATE && $stable(set_voltage);
	endproperty
	a_local_refuse: assert property (p_local_refuse) else $error("set value taken in local");
	property p_remote_on;
		od_req && od_op == CRAFE_OP_WRITE && od_index == CRAFE_IDX_REMOTE && od_len == 3'h2
		&& od_wdata[15:0] == CRAFE_CODE_ON && remote_allowed |=> remote_active && !od_abort;
	endproperty
	a_remote_on: assert property (p_remote_on) else $error("remote request not granted");
	property p_quant; set_voltage[0] == 1'b0; endproperty
	a_quant: assert property (p_quant) else $error("set value not quantised");
	property p_query;
		rx_valid && !od_req && !cfg_we && rx_id == base_reg + 11'h001 && rx_id != bcast_reg
		|=> tx_valid && tx_id == base_reg + 11'h002;
	endproperty
	a_query: assert property (p_query) else $error("query not answered on response id");
	property p_bcast;
		rx_valid && !od_req && rx_id == bcast_reg && rx_id != base_reg && rx_id != base_reg + 11'h001
		|=> !tx_valid;
	endproperty
	a_bcast: assert property (p_bcast) else $error("broadcast frame answered");
	property p_err_frame; tx_valid && tx_data[15:0] == CRAFE_REG_ERROR |-> tx_dlc == 4'h3; endproperty
	a_err_frame: assert property (p_err_frame) else $error("error frame length wrong");
	property p_arm; $rose(gen_armed) |-> submit_reg; endproperty
	a_arm: assert property (p_arm) else $error("generator armed without submit");
	property p_run; gen_run |-> gen_armed; endproperty
	a_run: assert property (p_run) else $error("generator runs unarmed");
endmodule
bind crafe_top crafe_checker crafe_checker_inst (.clk(clk), .sys_rst(sys_rst), .od_req(od_req), .od_op(od_op),
	.od_index(od_index), .od_len(od_len), .od_done(od_done), .od_abort(od_abort), .od_abort_code(od_abort_code),
	.rx_valid(rx_valid), .rx_id(rx_id), .tx_valid(tx_valid), .tx_id(tx_id), .tx_dlc(tx_dlc), .tx_data(tx_data),
	.cfg_we(cfg_we), .cfg_base_id(cfg_base_id), .cfg_bcast_id(cfg_bcast_id), .remote_allowed(remote_allowed),
	.remote_active(remote_active), .set_voltage(set_voltage), .gen_armed(gen_armed), .gen_run(gen_run),
	.od_wdata(od_wdata));

// >>> sim/crafe_host_model.sv
// host model issuing object and raw frame requests
`timescale 1ns/1ps
module crafe_host_model (
	// clock
	input wire logic clk,
	// object request
	output logic od_req,
	output crafe_pkg::crafe_op_t od_op,
	output logic [15:0] od_index,
	output logic [7:0] od_sub,
	output logic [2:0] od_len,
	output logic [31:0] od_wdata,
	// object answer
	input wire logic od_done,
	input wire logic od_abort,
	input wire logic [31:0] od_abort_code,
	input wire logic [31:0] od_rdata,
	// raw frames
	output logic rx_valid,
	output logic [10:0] rx_id,
	output logic [3:0] rx_dlc,
	output logic [63:0] rx_data,
	input wire logic tx_valid,
	input wire logic [10:0] tx_id,
	input wire logic [3:0] tx_dlc,
	input wire logic [63:0] tx_data
);
	import crafe_pkg::*;
	logic [31:0] a_code;
	logic [31:0] a_rdata;
	logic [1:0] a_flags;
	logic [79:0] a_tx;
	initial begin
		od_req = 1'b0;
		od_op = CRAFE_OP_READ;
		od_index = 16'h0000;
		od_sub = 8'h00;
		od_len = 3'h0;
		od_wdata = 32'h00000000;
		rx_valid = 1'b0;
		rx_id = 11'h000;
		rx_dlc = 4'h0;
		rx_data = 64'h0000000000000000;
	end
	// one message, byte count as given in len, one 16-bit value
	task automatic od(input crafe_op_t op, input logic [15:0] idx, input logic [7:0] sub, input logic [2:0] len,
		input logic [15:0] val);
		@(posedge clk);
		#2;
		od_req = 1'b1;
		od_op = op;
		od_index = idx;
		od_sub = sub;
		od_len = len;
		od_wdata = {16'h0000, val};
		@(posedge clk);
		#2;
		od_req = 1'b0;
		od_wdata = ~od_wdata;
		a_flags = {od_done, od_abort};
		a_code = od_abort_code;
		a_rdata = od_rdata;
	endtask
	// first two bytes select the register, identifier selects the access
	task automatic frame(input logic [10:0] id, input logic [3:0] dlc, input logic [15:0] reg_no,
		input logic [15:0] val);
		@(posedge clk);
		#2;
		rx_valid = 1'b1;
		rx_id = id;
		rx_dlc = dlc;
		rx_data = {24'h000000, val, 8'h01, reg_no};
		@(posedge clk);
		#2;
		rx_valid = 1'b0;
		rx_data = ~rx_data;
		a_tx = {tx_valid, tx_id, tx_dlc, tx_data};
	endtask
endmodule

// >>> sim/test_can_register_access_frontend.sv
// self-checking bench for the register access front end
`timescale 1ns/1ps
module test_can_register_access_frontend;
	import crafe_pkg::*;
	logic clk;
	logic sys_rst;
	logic cfg_we;
	logic [10:0] cfg_base_id;
	logic [10:0] cfg_bcast_id;
	logic remote_allowed;
	logic od_req;
	crafe_op_t od_op;
	logic [15:0] od_index;
	logic [7:0] od_sub;
	logic [2:0] od_len;
	logic [31:0] od_wdata;
	logic od_done;
	logic od_abort;
	logic [31:0] od_abort_code;
	logic [31:0] od_rdata;
	logic rx_valid;
	logic [10:0] rx_id;
	logic [3:0] rx_dlc;
	logic [63:0] rx_data;
	logic tx_valid;
	logic [10:0] tx_id;
	logic [3:0] tx_dlc;
	logic [63:0] tx_data;
	logic remote_active;
	logic [15:0] set_voltage;
	logic gen_armed;
	logic gen_run;
	logic gen_on_current;
	logic [15:0] set_current, gen_start_point, gen_end_point, gen_repeat, gen_vlimit, gen_ilimit, gen_plimit;
	int err_count;
	int checks_done;
	localparam logic [31:0] NOM_V = 32'h43FA0000;
	crafe_top crafe_top_inst (.clk(clk), .sys_rst(sys_rst), .od_req(od_req), .od_op(od_op), .od_index(od_index),
		.od_sub(od_sub), .od_len(od_len), .od_wdata(od_wdata), .od_done(od_done), .od_abort(od_abort),
		.od_abort_code(od_abort_code), .od_rdata(od_rdata), .rx_valid(rx_valid), .rx_id(rx_id), .rx_dlc(rx_dlc),
		.rx_data(rx_data), .tx_valid(tx_valid), .tx_id(tx_id), .tx_dlc(tx_dlc), .tx_data(tx_data), .cfg_we(cfg_we),
		.cfg_base_id(cfg_base_id), .cfg_bcast_id(cfg_bcast_id), .nominal_v_float(NOM_V),
		.remote_allowed(remote_allowed), .remote_active(remote_active), .set_voltage(set_voltage),
		.set_current(set_current), .gen_armed(gen_armed), .gen_run(gen_run), .gen_on_current(gen_on_current),
		.gen_start_point(gen_start_point), .gen_end_point(gen_end_point), .gen_repeat(gen_repeat),
		.gen_vlimit(gen_vlimit), .gen_ilimit(gen_ilimit), .gen_plimit(gen_plimit));
	crafe_host_model crafe_host_model_inst (.clk(clk), .od_req(od_req), .od_op(od_op), .od_index(od_index),
		.od_sub(od_sub), .od_len(od_len), .od_wdata(od_wdata), .od_done(od_done), .od_abort(od_abort),
		.od_abort_code(od_abort_code), .od_rdata(od_rdata), .rx_valid(rx_valid), .rx_id(rx_id), .rx_dlc(rx_dlc),
		.rx_data(rx_data), .tx_valid(tx_valid), .tx_id(tx_id), .tx_dlc(tx_dlc), .tx_data(tx_data));
	task automatic give_verdict();
		if (err_count == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		checks_done++;
		if (g !== e) begin
			err_count++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	// object answer: done, abort flag and code
	task automatic chk_od(input logic ab, input logic [31:0] code);
		chk("od_flags", {62'h0, 1'b1, ab}, {62'h0, crafe_host_model_inst.a_flags});
		if (ab) chk("od_abort_code", {32'h0, code}, {32'h0, crafe_host_model_inst.a_code});
	endtask
	// raw answer: valid, id, length and low register field
	task automatic chk_tx(input logic v, input logic [10:0] id, input logic [3:0] dlc, input logic [15:0] rg);
		chk("tx_valid", {63'h0, v}, {63'h0, crafe_host_model_inst.a_tx[79]});
		if (v) chk("tx_frame", {33'h0, id, dlc, rg}, {33'h0, crafe_host_model_inst.a_tx[78:64],
			crafe_host_model_inst.a_tx[15:0]});
	endtask
	task automatic w(input logic [15:0] idx, input logic [7:0] sub, input logic [2:0] len, input logic [15:0] v);
		crafe_host_model_inst.od(CRAFE_OP_WRITE, idx, sub, len, v);
	endtask
	task automatic set_ids(input logic [10:0] b, input logic [10:0] bc);
		@(posedge clk);
		#2;
		cfg_we = 1'b1;
		cfg_base_id = b;
		cfg_bcast_id = bc;
		@(posedge clk);
		#2;
		cfg_we = 1'b0;
	endtask
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		#200000;
		err_count++;
		give_verdict();
	end
	initial begin
		err_count = 0;
		checks_done = 0;
		sys_rst = 1'b1;
		cfg_we = 1'b0;
		cfg_base_id = 11'h000;
		cfg_bcast_id = 11'h7FF;
		remote_allowed = 1'b0;
		repeat (4) @(posedge clk);
		#2;
		sys_rst = 1'b0;
		crafe_host_model_inst.od(CRAFE_OP_READ, 16'h207A, 8'h00, 3'h4, 16'h0000);
		chk_od(1'b0, 32'h0);
		chk("nominal", {32'h0, NOM_V}, {32'h0, crafe_host_model_inst.a_rdata});
		w(16'h207A, 8'h00, 3'h4, 16'h1234);
		chk_od(1'b1, CRAFE_AB_ACCESS);
		crafe_host_model_inst.od(CRAFE_OP_READ, 16'h2000, 8'h00, 3'h2, 16'h0000);
		chk_od(1'b1, CRAFE_AB_NO_OBJ);
		crafe_host_model_inst.od(CRAFE_OP_BAD, 16'h2193, 8'h00, 3'h2, 16'h0000);
		chk_od(1'b1, CRAFE_AB_NO_CMD);
		w(CRAFE_IDX_SETV, 8'h00, 3'h2, 16'h1235);
		chk_od(1'b1, CRAFE_AB_STATE);
		w(CRAFE_IDX_REMOTE, 8'h00, 3'h2, CRAFE_CODE_ON);
		chk_od(1'b1, CRAFE_AB_STATE);
		remote_allowed = 1'b1;
		w(CRAFE_IDX_REMOTE, 8'h00, 3'h2, CRAFE_CODE_ON);
		chk("remote", 64'h1, {63'h0, remote_active});
		w(CRAFE_IDX_SETV, 8'h00, 3'h5, 16'h1235);
		chk_od(1'b1, CRAFE_AB_TOO_MUCH);
		w(CRAFE_IDX_SETV, 8'h00, 3'h1, 16'h1235);
		chk_od(1'b1, CRAFE_AB_TOO_LITTLE);
		w(CRAFE_IDX_SETV, 8'h00, 3'h2, CRAFE_FULL_SCALE);
		chk("setv_full", {48'h0, CRAFE_FULL_SCALE}, {48'h0, set_voltage});
		w(CRAFE_IDX_SETV, 8'h00, 3'h2, 16'h1235);
		chk("setv_quant", 64'h1234, {48'h0, set_voltage});
		w(CRAFE_IDX_PT_FIRST, 8'h01, 3'h2, 16'h0100);
		chk_od(1'b1, CRAFE_AB_STATE);
		w(CRAFE_IDX_GEN_VSEL, 8'h00, 3'h2, CRAFE_CODE_ON);
		w(CRAFE_IDX_SEQ_START, 8'h00, 3'h2, 16'h0001);
		w(CRAFE_IDX_SEQ_END, 8'h00, 3'h2, 16'h0001);
		w(CRAFE_IDX_REPEAT, 8'h00, 3'h2, 16'h0002);
		for (int s = 1; s <= 8; s++) begin
			w(CRAFE_IDX_PT_FIRST, s[7:0], 3'h2, 16'h0100);
			chk_od(1'b0, 32'h0);
		end
		w(CRAFE_IDX_PT_LAST, 8'h08, 3'h2, 16'h0200);
		chk_od(1'b0, 32'h0);
		w(CRAFE_IDX_PT_LAST, 8'h09, 3'h2, 16'h0200);
		chk_od(1'b1, CRAFE_AB_NO_SUB);
		w(CRAFE_IDX_PT_FIRST, 8'h00, 3'h2, 16'h0200);
		chk_od(1'b1, CRAFE_AB_NO_SUB);
		w(CRAFE_IDX_PT_FIRST, 8'h02, 3'h2, 16'hCCCD);
		chk_od(1'b1, CRAFE_AB_RANGE);
		w(CRAFE_IDX_GLIM_I, 8'h00, 3'h2, 16'h8000);
		w(CRAFE_IDX_GLIM_P, 8'h00, 3'h2, 16'h8000);
		chk("gen_cfg", 64'h0001_0001_0002_8000, {gen_start_point, gen_end_point, gen_repeat, gen_ilimit});
		chk("gen_lim", 64'h8000_1234_8000_0000, {gen_plimit, gen_vlimit, set_current, 15'h0, gen_on_current});
		chk("unarmed", 64'h0, {63'h0, gen_armed});
		crafe_host_model_inst.od(CRAFE_OP_READ, CRAFE_IDX_SUBMIT, 8'h00, 3'h2, 16'h0000);
		chk_od(1'b1, CRAFE_AB_ACCESS);
		w(CRAFE_IDX_SUBMIT, 8'h00, 3'h2, CRAFE_CODE_ON);
		chk("armed", 64'h1, {63'h0, gen_armed});
		w(CRAFE_IDX_GEN_RUN, 8'h00, 3'h2, CRAFE_CODE_ON);
		chk("run", 64'h1, {63'h0, gen_run});
		w(CRAFE_IDX_GEN_VSEL, 8'h00, 3'h2, CRAFE_CODE_OFF);
		chk("leave", 64'h0, {62'h0, gen_armed, gen_run});
		crafe_host_model_inst.frame(11'h001, 4'h2, 16'h0079, 16'h0000);
		chk_tx(1'b1, 11'h002, 4'h6, 16'h0079);
		crafe_host_model_inst.frame(11'h000, 4'h5, 16'h0079, 16'h0001);
		chk_tx(1'b1, 11'h002, 4'h3, CRAFE_REG_ERROR);
		set_ids(11'h100, 11'h200);
		crafe_host_model_inst.frame(11'h101, 4'h2, 16'h0079, 16'h0000);
		chk_tx(1'b1, 11'h102, 4'h6, 16'h0079);
		crafe_host_model_inst.frame(11'h001, 4'h2, 16'h0079, 16'h0000);
		chk_tx(1'b0, 11'h000, 4'h0, 16'h0000);
		crafe_host_model_inst.frame(11'h200, 4'h2, 16'h0079, 16'h0000);
		chk_tx(1'b0, 11'h000, 4'h0, 16'h0000);
		crafe_host_model_inst.frame(11'h200, 4'h5, 16'h01F4, 16'h0100);
		chk_tx(1'b0, 11'h000, 4'h0, 16'h0000);
		chk("bcast_write", 64'h0100, {48'h0, set_voltage});
		give_verdict();
	end
endmodule
